// *** bench/cii_periph.sv ***
// Far-side model: port devices, open-drain lines, one interrupt source.
// Assumes the unit changes its pins just after the rising edge of aclk.
`timescale 1ns/1ps
module cii_periph import cii_pkg::*; (
    input  wire logic       aclk,
    input  wire logic [3:0] port_select_code,
    input  wire logic       port_read,
    input  wire logic       port_strobe,
    input  wire logic [7:0] data_o,
    input  wire logic [6:0] direct_control_lines_oe_n,
    input  wire logic       irq_ack,
    input  wire logic       irq_enable_out,
    input  wire logic [7:0] in_val,
    input  wire logic [7:0] vec,
    input  wire logic [6:0] ext_low,
    input  wire logic       fire,
    output      logic [7:0] data_i,
    output      logic [6:0] direct_control_lines_i,
    output      logic       irq_req_n,
    output      logic [7:0] got,
    output      logic [3:0] got_sel,
    output      int         stb_cnt,
    output      int         ack_cnt
);
    logic raw_n;
    // ========================================================
    // Pins
    // Pull-up, low when pulled
    assign direct_control_lines_i =
        direct_control_lines_oe_n & ~ext_low;
    // Vector, port data or junk
    assign data_i = irq_ack ? vec : (port_read ? in_val : ~got);
    // Gated by the enable output
    assign irq_req_n = raw_n | ~irq_enable_out;
    initial begin
        raw_n   = 1'b1;
        got     = '0;
        got_sel = '0;
        stb_cnt = 0;
        ack_cnt = 0;
    end
    always @(posedge aclk) begin
        if (fire)
            raw_n <= 1'b0;
        if (irq_ack) begin
            raw_n   <= 1'b1;
            ack_cnt <= ack_cnt + 1;
        end
        if (port_strobe && !port_read) begin
            got     <= data_o;
            got_sel <= port_select_code;
            stb_cnt <= stb_cnt + 1;
        end
    end
endmodule

// *** bench/ctrl_io_interrupt_interface_tb_top.sv ***
// Self-checking bench for the control and interrupt unit.
// Assumes one 40 MHz clock for bus and far side.
`timescale 1ns/1ps
module ctrl_io_interrupt_interface_tb_top import cii_pkg::*;;
    localparam logic [7:0] VEC = 8'h40;
    logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid;
    logic        s_rready, s_awready, s_wready, s_bvalid, s_arready;
    logic        s_rvalid, port_read, port_strobe, data_oe_n, irq_req_n;
    logic        irq_ack, irq_enable_out, fire;
    logic [7:0]  s_awaddr, s_araddr, data_i, data_o, in_val, got;
    logic [31:0] s_wdata, s_rdata, d;
    logic [1:0]  s_bresp, s_rresp, r;
    logic [3:0]  s_wstrb, port_select_code, got_sel;
    logic [6:0]  direct_control_lines_i, direct_control_lines_o;
    logic [6:0]  direct_control_lines_oe_n, ext;
    int          stb_cnt, ack_cnt;
    int          error_cnt = 0;
    int          tests_run = 0;

    cii_top dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
        .s_rvalid, .s_rready, .port_select_code, .port_read, .port_strobe,
        .data_i, .data_o, .data_oe_n, .direct_control_lines_i,
        .direct_control_lines_o, .direct_control_lines_oe_n, .irq_req_n,
        .irq_ack, .irq_enable_out);
    cii_periph peer (.aclk, .port_select_code, .port_read, .port_strobe,
        .data_o, .direct_control_lines_oe_n, .irq_ack, .irq_enable_out,
        .in_val, .vec(VEC), .ext_low(ext), .fire, .data_i,
        .direct_control_lines_i, .irq_req_n, .got, .got_sel, .stb_cnt,
        .ack_cnt);

    // ========================================================
    // Bus and check tasks
    task automatic conclude(input logic to);
        if (to)
            error_cnt++;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] v,
                       output logic [1:0] rs);
        logic ta, tw, tk;
        int n = 0;
        s_awaddr  <= a;
        s_wdata   <= v;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_awready & s_awvalid;
            tw = s_wready & s_wvalid;
            tk = s_bvalid === 1'b1;
            rs = s_bresp;
            @(posedge aclk);
            if (ta) s_awvalid <= 1'b0;
            if (tw) s_wvalid <= 1'b0;
            n++;
        end while (!tk && n < 60);
        if (!tk) conclude(1'b1);
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] v,
                       output logic [1:0] rs);
        logic ta, tk;
        int n = 0;
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_arready & s_arvalid;
            tk = s_rvalid === 1'b1;
            v  = s_rdata;
            rs = s_rresp;
            @(posedge aclk);
            if (ta) s_arvalid <= 1'b0;
            n++;
        end while (!tk && n < 60);
        if (!tk) conclude(1'b1);
    endtask
    task automatic exec(input logic [7:0] op);
        int n = 0;
        axw(A_INSTR, {24'h0, op}, r);
        do begin
            axr(A_STAT, d, r);
            n++;
        end while (d[ST_BUSY] !== 1'b0 && n < 20);
        if (n == 20) conclude(1'b1);
        @(posedge aclk);
    endtask

    // ========================================================
    // Scenarios
    task automatic t_reset;
        chk("ien pin", 0, irq_enable_out);
        chk("ack pin", 0, irq_ack);
        axw(A_STAT, 32'h0, r);
        axr(A_STAT, d, r);
        chk("status", 32'h007f7f00, d);
        axr(8'h14, d, r);
        chk("rd resp", RESP_ERR, r);
        axw(8'h18, 32'h1, r);
        chk("wr resp", RESP_ERR, r);
    endtask
    task automatic t_ports;
        int c;
        axw(A_ACC, 32'ha5, r);
        exec({OP_OUT, 4'h3});
        chk("out data", 8'ha5, got);
        chk("out sel", 4'h3, got_sel);
        c = stb_cnt;
        exec(OP_NOP);
        chk("nop strobes", c, stb_cnt);
        in_val <= 8'h3c;
        exec({OP_IN, 4'he});
        axr(A_ACC, d, r);
        chk("in data", 8'h3c, d);
    endtask
    task automatic t_lines;
        for (int k = 0; k < NUM_DC; k++) begin
            exec({OP_CLC, 3'(k)});
            chk("low", 7'h7f & ~(7'h1 << k),
                direct_control_lines_oe_n);
            exec({OP_SFZ, 3'(k)});
            axr(A_STAT, d, r);
            chk("skip low", 1, d[ST_SKIP]);
            exec({OP_STC, 3'(k)});
            exec({OP_SFS, 3'(k)});
            axr(A_STAT, d, r);
            chk("flag set", 8'hff, {d[22:16], d[ST_SKIP]});
        end
        ext <= 7'h04;
        exec({OP_SFZ, 3'h2});
        axr(A_STAT, d, r);
        chk("unit busy", 1, d[ST_SKIP]);
        ext <= 7'h00;
        exec({OP_SFZ, 3'h2});
        axr(A_STAT, d, r);
        chk("unit done", 0, d[ST_SKIP]);
    endtask
    task automatic t_irq;
        int n;
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        repeat (20) @(posedge aclk);
        chk("masked", 0, ack_cnt);
        exec({OP_STC, IRQ_BIT});
        for (n = 0; n < 40 && (ack_cnt != 4 || irq_ack !== 1'b0); n++)
            @(negedge aclk);
        if (n == 40) conclude(1'b1);
        @(posedge aclk);
        chk("ack cycles", VEC_CYC, ack_cnt);
        chk("ien off", 0, irq_enable_out);
        axr(A_PC, d, r);
        chk("at vector", 1, d - VEC < 16);
        exec(OP_RTE);
        chk("ien on", 1, irq_enable_out);
    endtask

    // ========================================================
    // Clock, reset and sequence
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {s_awaddr, s_araddr, in_val, s_wdata} = '0;
        s_wstrb = 4'hf;
        fire = 1'b0;
        ext = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_ports();
        t_lines();
        t_irq();
        conclude(1'b0);
    end
endmodule

// *** rtl/cii_axil.sv ***
// AXI4-Lite slave for the control unit registers.
// Assumes one write and one read at most under way at a time.
`timescale 1ns/1ps
module cii_axil import cii_pkg::*; (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output      logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output      logic        wready,
    output      logic [1:0]  bresp,
    output      logic        bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output      logic        arready,
    output      logic [1:0]  rresp,
    output      logic        rvalid,
    input  wire logic        rready,
    cii_reg_if.bus           rif
);
    typedef struct packed {
        logic        awrdy;
        logic        wrdy;
        logic        arrdy;
        logic        awgot;
        logic        wgot;
        logic        bvalid;
        logic        rvalid;
        logic        wr_en;
        logic        rd_en;
        logic [1:0]  bresp;
        logic [1:0]  rresp;
        logic [7:0]  waddr;
        logic [7:0]  raddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
    } cii_axs_t;

    cii_axs_t q;
    cii_axs_t n;

    // ========================================================
    // Channel handling
    always_comb begin
        n = q;
        n.wr_en = 1'b0;
        n.rd_en = 1'b0;
        if (awvalid && q.awrdy) begin
            n.awgot = 1'b1;
            n.waddr = awaddr;
        end
        if (wvalid && q.wrdy) begin
            n.wgot  = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (q.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (q.awgot && q.wgot && !q.bvalid) begin
            n.awgot  = 1'b0;
            n.wgot   = 1'b0;
            n.bvalid = 1'b1;
            n.wr_en  = cii_addr_ok(q.waddr);
            n.bresp  = cii_addr_ok(q.waddr) ? RESP_OK : RESP_ERR;
        end
        n.awrdy = !n.awgot;
        n.wrdy  = !n.wgot;
        if (arvalid && q.arrdy) begin
            n.arrdy = 1'b0;
            n.raddr = araddr;
            n.rd_en = 1'b1;
        end
        if (q.rd_en) begin
            n.rvalid = 1'b1;
            n.rresp  = cii_addr_ok(q.raddr) ? RESP_OK : RESP_ERR;
        end
        if (q.rvalid && rready) begin
            n.rvalid = 1'b0;
            n.arrdy  = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q       <= '0;
            q.awrdy <= 1'b1;
            q.wrdy  <= 1'b1;
            q.arrdy <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign awready = q.awrdy;
    assign wready = q.wrdy;
    assign arready = q.arrdy;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign rvalid = q.rvalid;
    assign rresp = q.rresp;
    assign rif.wr_en = q.wr_en;
    assign rif.waddr = q.waddr;
    assign rif.wdata = q.wdata;
    assign rif.wstrb = q.wstrb;
    assign rif.rd_en = q.rd_en;
    assign rif.raddr = q.raddr;
endmodule

// *** rtl/cii_dcl.sv ***
// Bank of seven direct control flip-flops driving open-drain lines.
// Assumes set and clear strobes are never raised together.
`timescale 1ns/1ps
module cii_dcl import cii_pkg::*; (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       set_en,
    input  wire logic       clr_en,
    input  wire logic [2:0] idx,
    output      logic [6:0] ff
);
    typedef struct packed {
        logic [6:0] ff;
    } cii_dcs_t;

    cii_dcs_t q;
    cii_dcs_t n;

    // ========================================================
    // Set and clear by program only
    always_comb begin
        n = q;
        if (set_en && idx < 3'(NUM_DC)) begin
            n.ff[idx] = 1'b1; // see [RQ4]
        end else if (clr_en && idx < 3'(NUM_DC)) begin
            n.ff[idx] = 1'b0; // see [RQ7]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q.ff <= DC_RST;
        end else begin
            q <= n;
        end
    end

    assign ff = q.ff;

    // ========================================================
    // Checks
    dc_set_a: assert property ( // see [RQ4]
        @(posedge aclk) disable iff (!aresetn)
        set_en && idx < 3'(NUM_DC) |=> ff[$past(idx)])
        else $error("Control flop not set");
    dc_clr_a: assert property ( // see [RQ7]
        @(posedge aclk) disable iff (!aresetn)
        clr_en && idx < 3'(NUM_DC) |=> !ff[$past(idx)])
        else $error("Control flop not cleared");
endmodule

// *** rtl/cii_pkg.sv ***
// Shared constants, types and helpers.
// Assumes a 40 MHz aclk and 8-bit bus addresses.
package cii_pkg;

    // ========================================================
    // Register map
    localparam logic [7:0] A_INSTR = 8'h00;
    localparam logic [7:0] A_ACC   = 8'h04;
    localparam logic [7:0] A_STAT  = 8'h08;
    localparam logic [7:0] A_PC    = 8'h0c;
    localparam logic [7:0] A_IRR   = 8'h10;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    // Status field positions
    localparam int ST_BUSY = 0;
    localparam int ST_SKIP = 1;
    localparam int ST_IEN  = 2;
    localparam int ST_ACK  = 3;
    localparam int ST_LVL  = 8;
    localparam int ST_FF   = 16;

    // ========================================================
    // Instruction encodings
    localparam int         NUM_DC   = 7;
    localparam logic [3:0] OP_IN    = 4'h4;
    localparam logic [3:0] OP_OUT   = 4'h5;
    localparam logic [3:0] PORT_NOP = 4'hf;
    localparam logic [4:0] OP_STC   = 5'h05;
    localparam logic [4:0] OP_CLC   = 5'h15;
    localparam logic [4:0] OP_SFS   = 5'h03;
    localparam logic [4:0] OP_SFZ   = 5'h07;
    localparam logic [7:0] OP_RTI   = 8'hb0;
    localparam logic [7:0] OP_RTE   = 8'hb1;
    localparam logic [7:0] OP_NOP   = 8'h5f;
    localparam logic [2:0] IRQ_BIT  = 3'h7;

    // ========================================================
    // Reset values and timing
    localparam logic [6:0]  DC_RST = 7'h7f;
    localparam logic [10:0] PC_RST = 11'h000;
    localparam logic [10:0] PC_ONE = 11'h001;
    localparam logic [10:0] PC_TWO = 11'h002;
    localparam int          CLK_NS = 25;
    localparam int          VEC_NS = 100;
    localparam int          VEC_CYC = (VEC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0]  VEC_LAST = 3'(VEC_CYC - 1);

    typedef enum logic [1:0] {
        CII_FETCH = 2'h0,
        CII_EXEC  = 2'h1,
        CII_INTR  = 2'h3
    } cii_phase_t;

    // ========================================================
    // Helpers
    function automatic logic cii_addr_ok(input logic [7:0] a);
        return a == A_INSTR || a == A_ACC || a == A_STAT ||
               a == A_PC || a == A_IRR;
    endfunction

    function automatic logic cii_ctl(input logic [7:0] op,
                                     input logic [4:0] code);
        return op[7:3] == code;
    endfunction

endpackage

// *** rtl/cii_reg_if.sv ***
// Register access path between the bus slave and the core.
// Assumes one-cycle strobes, read data next cycle.
`timescale 1ns/1ps
interface cii_reg_if;
    logic        wr_en;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        rd_en;
    logic [7:0]  raddr;
    logic [31:0] rdata;

    modport bus  (output wr_en, waddr, wdata, wstrb, rd_en, raddr,
                  input rdata);
    modport core (input wr_en, waddr, wdata, wstrb, rd_en, raddr,
                  output rdata);
endinterface

// *** rtl/cii_top.sv ***
// Port, control line and interrupt unit.
// Assumes synchronous pins and an AXI4-Lite master on aclk.
//
// Contract
// [RQ1] Sixteen input, fifteen output ports by select code
// [RQ2] Output to port 17 octal is a no-op
// [RQ3] Seven bidirectional control lines, four usage modes
// [RQ4] Static output level set or cleared by program
// [RQ5] Input flag: set flop, then test line
// [RQ6] Handshake: pull low, external holds, then test
// [RQ7] Internal flag: set, clear and test flop
// [RQ8] Request in, acknowledge out, enable out
// [RQ9] Request sampled every execute except clear 7
// [RQ10] Acknowledge high throughout the interrupt phase
// [RQ11] Interrupt phase clears enable, loads vector, saves return
// [RQ12] Request unmasked; outside gates it with enable
// [RQ13] Source withdraws request or gets second phase
// [RQ14] Source puts vector out within 100 ns
// [RQ15] Latency over minimum at most one instruction
// [RQ16] Request to service fetch within three phases
// [RQ17] Clock must pulse soon after supply valid
// [RQ18] Return-and-enable jumps back and sets enable
// [RQ19] Output opcode 0101 plus select drives accumulator
// [RQ20] Skip-if-low opcode 00111 plus line number
// [RQ21] Acknowledge drops before service fetch begins
// [RQ22] Request sampled once at fixed execute edge
`timescale 1ns/1ps
module cii_top import cii_pkg::*; (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output      logic        s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output      logic        s_wready,
    output      logic [1:0]  s_bresp,
    output      logic        s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output      logic        s_arready,
    output      logic [31:0] s_rdata,
    output      logic [1:0]  s_rresp,
    output      logic        s_rvalid,
    input  wire logic        s_rready,
    output      logic [3:0]  port_select_code,
    output      logic        port_read,
    output      logic        port_strobe,
    input  wire logic [7:0]  data_i,
    output      logic [7:0]  data_o,
    output      logic        data_oe_n,
    input  wire logic [6:0]  direct_control_lines_i,
    output      logic [6:0]  direct_control_lines_o,
    output      logic [6:0]  direct_control_lines_oe_n,
    input  wire logic        irq_req_n,
    output      logic        irq_ack,
    output      logic        irq_enable_out
);
    typedef struct packed {
        cii_phase_t  phase;
        logic [2:0]  vcnt;
        logic [7:0]  instr;
        logic        pend;
        logic [7:0]  pend_op;
        logic [7:0]  acc;
        logic [10:0] pc;
        logic [10:0] irq_return_register;
        logic        irq_en;
        logic        ack;
        logic [3:0]  sel;
        logic        rd;
        logic        strobe;
        logic [7:0]  dout;
        logic        doe_n;
        logic        skip;
        logic [31:0] rdata;
        logic        dc_set;
        logic        dc_clr;
        logic [2:0]  dc_idx;
    } cii_core_t;

    cii_core_t  q;
    cii_core_t  n;
    cii_reg_if  rif ();
    logic [6:0] dc_ff;
    logic       lvl;
    logic       is_out;
    logic       is_io;
    logic       nop_out;
    logic       masked;

    // ========================================================
    // Bus slave and control line bank
    cii_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_awaddr),
        .awvalid(s_awvalid),
        .awready(s_awready),
        .wdata(s_wdata),
        .wstrb(s_wstrb),
        .wvalid(s_wvalid),
        .wready(s_wready),
        .bresp(s_bresp),
        .bvalid(s_bvalid),
        .bready(s_bready),
        .araddr(s_araddr),
        .arvalid(s_arvalid),
        .arready(s_arready),
        .rresp(s_rresp),
        .rvalid(s_rvalid),
        .rready(s_rready),
        .rif(rif.bus)
    );

    cii_dcl u_dcl (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_en(q.dc_set),
        .clr_en(q.dc_clr),
        .idx(q.dc_idx),
        .ff(dc_ff)
    );

    // ========================================================
    // Instruction decode
    always_comb begin
        if (q.instr[2:0] == IRQ_BIT) begin
            lvl = q.irq_en;
        end else begin
            lvl = direct_control_lines_i[q.instr[2:0]]; // see [RQ5]
        end
        masked  = cii_ctl(q.instr, OP_CLC) && q.instr[2:0] == IRQ_BIT;
        is_out  = q.pend_op[7:4] == OP_OUT;
        is_io   = is_out || q.pend_op[7:4] == OP_IN;
        nop_out = is_out && q.pend_op[3:0] == PORT_NOP;
    end

    // ========================================================
    // Registers and instruction sequencer
    always_comb begin
        n = q;
        n.dc_set = 1'b0;
        n.dc_clr = 1'b0;
        if (rif.wr_en && rif.wstrb[0]) begin
            if (rif.waddr == A_INSTR) begin
                if (!q.pend) begin
                    n.pend    = 1'b1;
                    n.pend_op = rif.wdata[7:0];
                end
            end else if (rif.waddr == A_ACC) begin
                n.acc = rif.wdata[7:0];
            end else if (rif.waddr == A_PC) begin
                n.pc[7:0] = rif.wdata[7:0];
            end
        end
        if (rif.wr_en && rif.wstrb[1] && rif.waddr == A_PC) begin
            n.pc[10:8] = rif.wdata[10:8];
        end
        if (rif.rd_en) begin
            n.rdata = '0;
            if (rif.raddr == A_INSTR) begin
                n.rdata[7:0] = q.pend_op;
            end else if (rif.raddr == A_ACC) begin
                n.rdata[7:0] = q.acc;
            end else if (rif.raddr == A_STAT) begin
                n.rdata[ST_BUSY] = q.pend;
                n.rdata[ST_SKIP] = q.skip;
                n.rdata[ST_IEN]  = q.irq_en;
                n.rdata[ST_ACK]  = q.ack;
                n.rdata[ST_LVL +: NUM_DC] = direct_control_lines_i;
                n.rdata[ST_FF +: NUM_DC]  = dc_ff;
            end else if (rif.raddr == A_PC) begin
                n.rdata[10:0] = q.pc;
            end else if (rif.raddr == A_IRR) begin
                n.rdata[10:0] = q.irq_return_register;
            end
        end
        case (q.phase)
            CII_FETCH: begin
                n.phase = CII_EXEC;
                n.instr = OP_NOP;
                if (q.pend) begin
                    n.pend  = 1'b0;
                    n.instr = q.pend_op;
                    n.sel   = q.pend_op[3:0]; // see [RQ1]
                    n.rd    = !is_out;
                    n.strobe = is_io && !nop_out; // see [RQ2]
                    n.doe_n  = !(is_out && !nop_out);
                    n.dout   = q.acc; // see [RQ19]
                end
            end
            CII_EXEC: begin
                n.strobe = 1'b0;
                n.doe_n  = 1'b1;
                n.skip   = q.skip && q.instr == OP_NOP;
                n.pc     = q.pc + PC_ONE;
                if (q.instr[7:4] == OP_IN) begin
                    n.acc = data_i;
                end else if (cii_ctl(q.instr, OP_STC)) begin
                    if (q.instr[2:0] == IRQ_BIT) begin
                        n.irq_en = 1'b1;
                    end else begin
                        n.dc_set = 1'b1; // see [RQ3]
                        n.dc_idx = q.instr[2:0];
                    end
                end else if (cii_ctl(q.instr, OP_CLC)) begin
                    if (q.instr[2:0] == IRQ_BIT) begin
                        n.irq_en = 1'b0;
                    end else begin
                        n.dc_clr = 1'b1; // see [RQ6]
                        n.dc_idx = q.instr[2:0];
                    end
                end else if (cii_ctl(q.instr, OP_SFS)) begin
                    n.skip = lvl;
                end else if (cii_ctl(q.instr, OP_SFZ)) begin
                    n.skip = !lvl; // see [RQ20]
                end else if (q.instr == OP_RTI) begin
                    n.pc = q.irq_return_register;
                end else if (q.instr == OP_RTE) begin
                    n.pc     = q.irq_return_register; // see [RQ18]
                    n.irq_en = 1'b1;
                end
                if (n.skip && q.instr != OP_NOP) begin
                    n.pc = q.pc + PC_TWO;
                end
                if (!irq_req_n && !masked) begin // see [RQ9] [RQ22]
                    n.phase  = CII_INTR;
                    n.ack    = 1'b1; // see [RQ10]
                    n.irq_en = 1'b0; // see [RQ11]
                    n.vcnt   = '0;
                end else begin
                    n.phase = CII_FETCH;
                end
            end
            CII_INTR: begin
                n.vcnt = q.vcnt + 3'h1;
                if (q.vcnt == VEC_LAST) begin // see [RQ14] [RQ16]
                    n.irq_return_register    = q.pc; // see [RQ11]
                    n.pc     = {3'h0, data_i};
                    n.ack    = 1'b0; // see [RQ21]
                    n.phase  = CII_FETCH; // see [RQ15]
                end
            end
            default: begin
                n.phase = CII_FETCH;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q       <= '0;
            q.phase <= CII_FETCH;
            q.instr <= OP_NOP;
            q.pc    <= PC_RST;
            q.irq_return_register   <= PC_RST;
            q.doe_n <= 1'b1;
            q.rd    <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // ========================================================
    // Outputs
    assign rif.rdata = q.rdata;
    assign s_rdata = q.rdata;
    assign port_select_code = q.sel;
    assign port_read = q.rd;
    assign port_strobe = q.strobe;
    assign data_o = q.dout;
    assign data_oe_n = q.doe_n;
    assign direct_control_lines_o = '0;
    assign direct_control_lines_oe_n = dc_ff; // see [RQ6]
    assign irq_ack = q.ack; // see [RQ8]
    assign irq_enable_out = q.irq_en;

    // ========================================================
    // Checks
    default clocking cii_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    localparam int INT_MAX = 4;

    port_nop_a: assert property ( // see [RQ2]
        q.phase == CII_EXEC && q.instr == OP_NOP |-> !port_strobe)
        else $error("Strobe on no-op");
    out_drive_a: assert property ( // see [RQ19]
        port_strobe && !port_read |-> !data_oe_n && data_o == q.acc)
        else $error("Output data not accumulator");
    irq_take_a: assert property ( // see [RQ9]
        q.phase == CII_EXEC && !irq_req_n && !masked
        |=> irq_ack && q.phase == CII_INTR && !irq_enable_out)
        else $error("Interrupt phase not entered");
    irq_skip_a: assert property ( // see [RQ9]
        q.phase == CII_EXEC && masked |=> q.phase == CII_FETCH)
        else $error("Request taken in disable");
    ack_phase_a: assert property ( // see [RQ10]
        irq_ack == (q.phase == CII_INTR))
        else $error("Acknowledge outside phase");
    int_len_a: assert property ( // see [RQ16]
        $rose(irq_ack) |-> irq_ack [*4] ##1 !irq_ack)
        else $error("Ack length wrong");
    int_end_a: assert property ( // see [RQ21]
        q.phase == CII_INTR |-> ##[1:INT_MAX] q.phase == CII_FETCH)
        else $error("Interrupt phase stuck");
    vec_load_a: assert property ( // see [RQ11]
        q.phase == CII_INTR && q.vcnt == VEC_LAST
        |=> q.pc == {3'h0, $past(data_i)} && q.irq_return_register == $past(q.pc)
            && !irq_ack)
        else $error("Vector not taken");
    rte_back_a: assert property ( // see [RQ18]
        q.phase == CII_EXEC && q.instr == OP_RTE && irq_req_n
        |=> irq_enable_out && q.pc == $past(q.irq_return_register))
        else $error("Return and enable failed");
    skip_low_a: assert property ( // see [RQ20]
        q.phase == CII_EXEC && cii_ctl(q.instr, OP_SFZ) && !lvl
        |=> q.skip && q.pc == $past(q.pc) + PC_TWO)
        else $error("Skip on low missed");

    irq_seen_c: cover property ($rose(irq_ack) ##[1:8] $fell(irq_ack));
    out_seen_c: cover property (port_strobe && !port_read);
    rte_seen_c: cover property (q.phase == CII_EXEC && q.instr == OP_RTE);
    skip_seen_c: cover property ($rose(q.skip));
endmodule
